// ==== pin_relocation_pkg.sv ====
// Package for the peripheral pin relocation block: register map and field positions.
// Assumes a 32-bit APB with one aligned word per relocation register.
package pin_relocation_pkg;

  // Register byte addresses
  localparam logic [11:0] IRQ_NMI_TRIGGER_PIN_SELECT_ADDR = 12'h000;
  localparam logic [11:0] SERIAL_7_8_PIN_SELECT_ADDR = 12'h004;
  localparam logic [11:0] CLOCK_OUT0_PIN_SELECT_ADDR = 12'h008;
  localparam logic [11:0] SERIAL2_PIN_SELECT_ADDR = 12'h00c;

  // Writable (implemented) bits of each register, all others reserved
  localparam logic [7:0] IRQ_NMI_TRIGGER_MASK = 8'h0b;
  localparam logic [7:0] SERIAL_7_8_MASK = 8'h3f;
  localparam logic [7:0] CLOCK_OUT0_MASK = 8'h20;
  localparam logic [7:0] SERIAL2_MASK = 8'h08;
  localparam logic [7:0] SELECT_RESET = 8'h00;

  // Field positions inside the byte (upper-byte registers: bit n+8 maps to n)
  localparam int EXT_IRQ3_SECOND_ALT_BIT = 3;
  localparam int NMI_ALT_BIT = 1;
  localparam int CONVERTER_TRIGGER_ALT_BIT = 0;
  localparam int SERIAL8_CLOCK_ALT_BIT = 5;
  localparam int SERIAL8_TX_ALT_BIT = 4;
  localparam int SERIAL8_RX_ALT_BIT = 3;
  localparam int SERIAL7_CLOCK_ALT_BIT = 2;
  localparam int SERIAL7_TX_ALT_BIT = 1;
  localparam int SERIAL7_RX_ALT_BIT = 0;
  localparam int CLOCK_OUT0_ALT_BIT = 5;
  localparam int SERIAL2_RX_ALT_BIT = 3;

  localparam int NUM_SERIAL = 2;
  localparam int SYNC_STAGES = 2;

endpackage : pin_relocation_pkg

// ==== pin_sync_if.sv ====
// Interface carrying raw pin levels into the synchroniser and clean levels out.
// Assumes one clock domain on the sampling side.
`timescale 1ns/1ns
`default_nettype none

interface pin_sync_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;
  modport owner (output raw, input clean);
  modport sync (input raw, output clean);
endinterface : pin_sync_if

`default_nettype wire

// ==== pin_sync.sv ====
// Two-flip-flop synchroniser for a vector of pin levels.
// Assumes inputs asynchronous to clock; only the second stage is read outside.
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Pin levels
  pin_sync_if.sync pins
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  always_comb begin
    meta_next = pins.raw;
    stable_next = meta_reg;
    if (!rstn) begin
      meta_next = '0;
      stable_next = '0;
    end
  end

  always_ff @(posedge clock) begin
    meta_reg <= meta_next;
    stable_reg <= stable_next;
  end

  assign pins.clean = stable_reg;

endmodule : pin_sync

`default_nettype wire

// ==== peripheral_pin_relocation.sv ====
// Peripheral pin relocation: APB-programmed selects route peripheral signals
// between primary and alternate package pins.
// Assumes APB master on clock; pad inputs asynchronous; peripherals on clock.
// What this block does
// - Serial 2 select set routes alternate receive pin; bits two to zero reserved.
// - Reserved bits stay unchanged by any write, including read-modify-write.
// - Second interrupt-3 select picks primary or second alternate pin when first is zero.
// - NMI select picks primary or alternate NMI pin for interrupt logic.
// - Converter trigger select picks primary or alternate trigger pin.
// - Serial 8 clock select moves bidirectional clock, both directions.
// - Serial 8 transmit select drives data out on primary or alternate pin.
// - Serial 8 receive select feeds data in from primary or alternate pin.
// - Serial 7 clock select moves bidirectional clock, both directions.
// - Serial 7 transmit select drives data out on primary or alternate pin.
// - Serial 7 receive select feeds data in from primary or alternate pin.
// - Clock output 0 select drives clock out on primary or alternate pin.
`timescale 1ns/1ns
`default_nettype none

module peripheral_pin_relocation
  import pin_relocation_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Select kept outside this block
  input wire logic ext_irq3_first_alt_select,
  // Interrupt, trigger and serial 2 receive pins
  input wire logic ext_irq3_primary_pin,
  input wire logic ext_irq3_first_alt_pin,
  input wire logic ext_irq3_second_alt_pin,
  input wire logic nmi_primary_pin,
  input wire logic nmi_alt_pin,
  input wire logic converter_trigger_pin,
  input wire logic converter_trigger_alt_pin,
  input wire logic serial2_rx_primary_pin,
  input wire logic serial2_rx_alt_pin,
  // Serial 7/8 and clock output 0 pins, index 0 is channel 7, index 1 channel 8
  input wire logic [NUM_SERIAL-1:0] serial_rx_primary_pin,
  input wire logic [NUM_SERIAL-1:0] serial_rx_alt_pin,
  output logic [NUM_SERIAL-1:0] serial_tx_primary_out,
  output logic [NUM_SERIAL-1:0] serial_tx_primary_oe,
  output logic [NUM_SERIAL-1:0] serial_tx_alt_out,
  output logic [NUM_SERIAL-1:0] serial_tx_alt_oe,
  input wire logic [NUM_SERIAL-1:0] serial_clock_primary_in,
  input wire logic [NUM_SERIAL-1:0] serial_clock_alt_in,
  output logic [NUM_SERIAL-1:0] serial_clock_primary_out,
  output logic [NUM_SERIAL-1:0] serial_clock_primary_oe,
  output logic [NUM_SERIAL-1:0] serial_clock_alt_out,
  output logic [NUM_SERIAL-1:0] serial_clock_alt_oe,
  output logic clock_out0_pin,
  output logic clock_out0_pin_oe,
  output logic clock_out0_alt_pin,
  output logic clock_out0_alt_pin_oe,
  // Peripheral side
  input wire logic [NUM_SERIAL-1:0] serial_tx_data,
  input wire logic [NUM_SERIAL-1:0] serial_tx_enable,
  input wire logic [NUM_SERIAL-1:0] serial_clock_data,
  input wire logic [NUM_SERIAL-1:0] serial_clock_enable,
  output logic [NUM_SERIAL-1:0] serial_rx_data,
  output logic [NUM_SERIAL-1:0] serial_clock_in,
  output logic serial2_rx_data,
  output logic ext_irq3_in,
  output logic nmi_in,
  output logic converter_trigger_in,
  input wire logic clock_out0_source
);

  ////////////////////////////////////////////////////////////////////////////
  // Pad synchronisers

  localparam int NUM_SYNC = 9 + 4 * NUM_SERIAL;

  pin_sync_if #(.WIDTH(NUM_SYNC)) pad_if ();

  assign pad_if.raw = {ext_irq3_primary_pin, ext_irq3_first_alt_pin, ext_irq3_second_alt_pin,
                       nmi_primary_pin, nmi_alt_pin, converter_trigger_pin,
                       converter_trigger_alt_pin, serial2_rx_primary_pin, serial2_rx_alt_pin,
                       serial_rx_primary_pin, serial_rx_alt_pin,
                       serial_clock_primary_in, serial_clock_alt_in};

  pin_sync #(.WIDTH(NUM_SYNC)) pad_sync (
    .clock(clock),
    .rstn(rstn),
    .pins(pad_if.sync)
  );

  logic irq3_p, irq3_a1, irq3_a2, nmi_p, nmi_a, trig_p, trig_a, s2_p, s2_a;
  logic [NUM_SERIAL-1:0] rx_p, rx_a, ck_p, ck_a;

  assign {irq3_p, irq3_a1, irq3_a2, nmi_p, nmi_a, trig_p, trig_a, s2_p, s2_a,
          rx_p, rx_a, ck_p, ck_a} = pad_if.clean;

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] irq_nmi_trigger_pin_select_reg, irq_nmi_trigger_pin_select_next;
  logic [7:0] serial_7_8_pin_select_reg, serial_7_8_pin_select_next;
  logic [7:0] clock_out0_pin_select_reg, clock_out0_pin_select_next;
  logic [7:0] serial2_pin_select_reg, serial2_pin_select_next;
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_next;

  // Only implemented bits take write data; reserved positions hold zero
  function automatic logic [7:0] masked_write(input logic [7:0] data, input logic [7:0] mask);
    masked_write = data & mask;
  endfunction : masked_write

  function automatic logic addr_known(input logic [11:0] addr);
    addr_known = (addr == IRQ_NMI_TRIGGER_PIN_SELECT_ADDR) ||
                 (addr == SERIAL_7_8_PIN_SELECT_ADDR) ||
                 (addr == CLOCK_OUT0_PIN_SELECT_ADDR) ||
                 (addr == SERIAL2_PIN_SELECT_ADDR);
  endfunction : addr_known

  logic setup_phase;
  logic write_take;
  assign setup_phase = psel && !penable;
  assign write_take = psel && penable && pwrite && pready;

  always_comb begin
    irq_nmi_trigger_pin_select_next = irq_nmi_trigger_pin_select_reg;
    serial_7_8_pin_select_next = serial_7_8_pin_select_reg;
    clock_out0_pin_select_next = clock_out0_pin_select_reg;
    serial2_pin_select_next = serial2_pin_select_reg;
    prdata_next = prdata;
    // No wait state: ready rises in the access phase's first cycle
    pready_next = setup_phase;
    pslverr_next = setup_phase && !addr_known(paddr);
    if (setup_phase && !pwrite) begin
      case (paddr)
        IRQ_NMI_TRIGGER_PIN_SELECT_ADDR:
          prdata_next = {24'h000000, irq_nmi_trigger_pin_select_reg};
        SERIAL_7_8_PIN_SELECT_ADDR: prdata_next = {24'h000000, serial_7_8_pin_select_reg};
        CLOCK_OUT0_PIN_SELECT_ADDR: prdata_next = {24'h000000, clock_out0_pin_select_reg};
        SERIAL2_PIN_SELECT_ADDR: prdata_next = {24'h000000, serial2_pin_select_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
    if (write_take) begin
      case (paddr)
        IRQ_NMI_TRIGGER_PIN_SELECT_ADDR:
          irq_nmi_trigger_pin_select_next =
            masked_write(pwdata[7:0], IRQ_NMI_TRIGGER_MASK);
        SERIAL_7_8_PIN_SELECT_ADDR:
          serial_7_8_pin_select_next = masked_write(pwdata[7:0], SERIAL_7_8_MASK);
        CLOCK_OUT0_PIN_SELECT_ADDR:
          clock_out0_pin_select_next = masked_write(pwdata[7:0], CLOCK_OUT0_MASK);
        SERIAL2_PIN_SELECT_ADDR:
          serial2_pin_select_next = masked_write(pwdata[7:0], SERIAL2_MASK);
        default: ;
      endcase
    end
    if (!rstn) begin
      irq_nmi_trigger_pin_select_next = SELECT_RESET;
      serial_7_8_pin_select_next = SELECT_RESET;
      clock_out0_pin_select_next = SELECT_RESET;
      serial2_pin_select_next = SELECT_RESET;
      prdata_next = 32'h00000000;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    irq_nmi_trigger_pin_select_reg <= irq_nmi_trigger_pin_select_next;
    serial_7_8_pin_select_reg <= serial_7_8_pin_select_next;
    clock_out0_pin_select_reg <= clock_out0_pin_select_next;
    serial2_pin_select_reg <= serial2_pin_select_next;
    prdata <= prdata_next;
    pready <= pready_next;
    pslverr <= pslverr_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing

  logic [NUM_SERIAL-1:0] tx_sel, rx_sel, ck_sel;
  assign tx_sel = {serial_7_8_pin_select_reg[SERIAL8_TX_ALT_BIT],
                   serial_7_8_pin_select_reg[SERIAL7_TX_ALT_BIT]};
  assign rx_sel = {serial_7_8_pin_select_reg[SERIAL8_RX_ALT_BIT],
                   serial_7_8_pin_select_reg[SERIAL7_RX_ALT_BIT]};
  assign ck_sel = {serial_7_8_pin_select_reg[SERIAL8_CLOCK_ALT_BIT],
                   serial_7_8_pin_select_reg[SERIAL7_CLOCK_ALT_BIT]};

  logic [NUM_SERIAL-1:0] tx_p_out_next, tx_p_oe_next, tx_a_out_next, tx_a_oe_next;
  logic [NUM_SERIAL-1:0] ck_p_out_next, ck_p_oe_next, ck_a_out_next, ck_a_oe_next;
  logic [NUM_SERIAL-1:0] rx_data_next, ck_in_next;

  // Unselected pad is released and ignored so two pads never fight
  genvar ch;
  generate
    for (ch = 0; ch < NUM_SERIAL; ch++) begin : g_serial
      always_comb begin
        tx_p_out_next[ch] = !tx_sel[ch] && serial_tx_data[ch];
        tx_p_oe_next[ch] = !tx_sel[ch] && serial_tx_enable[ch];
        tx_a_out_next[ch] = tx_sel[ch] && serial_tx_data[ch];
        tx_a_oe_next[ch] = tx_sel[ch] && serial_tx_enable[ch];
        ck_p_out_next[ch] = !ck_sel[ch] && serial_clock_data[ch];
        ck_p_oe_next[ch] = !ck_sel[ch] && serial_clock_enable[ch];
        ck_a_out_next[ch] = ck_sel[ch] && serial_clock_data[ch];
        ck_a_oe_next[ch] = ck_sel[ch] && serial_clock_enable[ch];
        ck_in_next[ch] = ck_sel[ch] ? ck_a[ch] : ck_p[ch];
        rx_data_next[ch] = rx_sel[ch] ? rx_a[ch] : rx_p[ch];
        if (!rstn) begin
          {tx_p_out_next[ch], tx_p_oe_next[ch], tx_a_out_next[ch], tx_a_oe_next[ch]} = 4'h0;
          {ck_p_out_next[ch], ck_p_oe_next[ch], ck_a_out_next[ch], ck_a_oe_next[ch]} = 4'h0;
          {rx_data_next[ch], ck_in_next[ch]} = 2'h0;
        end
      end
    end
  endgenerate

  logic irq3_next, nmi_next, trig_next, s2_next;
  logic co_p_next, co_p_oe_next, co_a_next, co_a_oe_next;
  logic co_sel;
  assign co_sel = clock_out0_pin_select_reg[CLOCK_OUT0_ALT_BIT];

  always_comb begin
    if (ext_irq3_first_alt_select) begin
      irq3_next = irq3_a1;
    end else if (irq_nmi_trigger_pin_select_reg[EXT_IRQ3_SECOND_ALT_BIT]) begin
      irq3_next = irq3_a2;
    end else begin
      irq3_next = irq3_p;
    end
    nmi_next = irq_nmi_trigger_pin_select_reg[NMI_ALT_BIT] ? nmi_a : nmi_p;
    trig_next = irq_nmi_trigger_pin_select_reg[CONVERTER_TRIGGER_ALT_BIT] ? trig_a
      : trig_p;
    s2_next = serial2_pin_select_reg[SERIAL2_RX_ALT_BIT] ? s2_a : s2_p;
    co_p_next = !co_sel && clock_out0_source;
    co_p_oe_next = !co_sel;
    co_a_next = co_sel && clock_out0_source;
    co_a_oe_next = co_sel;
    if (!rstn) begin
      {irq3_next, nmi_next, trig_next, s2_next} = 4'h0;
      {co_p_next, co_p_oe_next, co_a_next, co_a_oe_next} = 4'h0;
    end
  end

  // All outputs registered; one cycle latency through the mux
  always_ff @(posedge clock) begin
    serial_tx_primary_out <= tx_p_out_next;
    serial_tx_primary_oe <= tx_p_oe_next;
    serial_tx_alt_out <= tx_a_out_next;
    serial_tx_alt_oe <= tx_a_oe_next;
    serial_clock_primary_out <= ck_p_out_next;
    serial_clock_primary_oe <= ck_p_oe_next;
    serial_clock_alt_out <= ck_a_out_next;
    serial_clock_alt_oe <= ck_a_oe_next;
    serial_rx_data <= rx_data_next;
    serial_clock_in <= ck_in_next;
    serial2_rx_data <= s2_next;
    ext_irq3_in <= irq3_next;
    nmi_in <= nmi_next;
    converter_trigger_in <= trig_next;
    clock_out0_pin <= co_p_next;
    clock_out0_pin_oe <= co_p_oe_next;
    clock_out0_alt_pin <= co_a_next;
    clock_out0_alt_pin_oe <= co_a_oe_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (!rstn)
    ((irq_nmi_trigger_pin_select_reg & ~IRQ_NMI_TRIGGER_MASK) == 8'h00) &&
    ((serial_7_8_pin_select_reg & ~SERIAL_7_8_MASK) == 8'h00))
    else $error("Reserved select bit set");

  AST_IRQ3_ROUTE: assert property (@(posedge clock) disable iff (!rstn)
    (!ext_irq3_first_alt_select && !irq_nmi_trigger_pin_select_reg[EXT_IRQ3_SECOND_ALT_BIT])
    |=> ext_irq3_in == $past(irq3_p))
    else $error("Interrupt 3 not from primary pin");

  AST_IRQ3_FIRST: assert property (@(posedge clock) disable iff (!rstn)
    ext_irq3_first_alt_select |=> ext_irq3_in == $past(irq3_a1))
    else $error("Interrupt 3 not from first alternate pin");

  AST_NMI_ROUTE: assert property (@(posedge clock) disable iff (!rstn)
    ##1 nmi_in == ($past(irq_nmi_trigger_pin_select_reg[NMI_ALT_BIT]) ? $past(nmi_a)
                                                                     : $past(nmi_p)))
    else $error("NMI routed from wrong pin");

  AST_TRIG_ROUTE: assert property (@(posedge clock) disable iff (!rstn)
    irq_nmi_trigger_pin_select_reg[CONVERTER_TRIGGER_ALT_BIT] |=>
      converter_trigger_in == $past(trig_a))
    else $error("Trigger not from alternate pin");

  AST_TX_EXCLUSIVE: assert property (@(posedge clock) disable iff (!rstn)
    ((serial_tx_primary_oe & serial_tx_alt_oe) == '0) &&
    ((serial_clock_primary_oe & serial_clock_alt_oe) == '0))
    else $error("Both pads driven");

  AST_TX_FOLLOW: assert property (@(posedge clock) disable iff (!rstn)
    (serial_tx_enable[1] && tx_sel[1]) |=> serial_tx_alt_oe[1] && !serial_tx_primary_oe[1])
    else $error("Serial 8 output on wrong pad");

  AST_RX7_ROUTE: assert property (@(posedge clock) disable iff (!rstn)
    !rx_sel[0] |=> serial_rx_data[0] == $past(rx_p[0]))
    else $error("Serial 7 input from wrong pad");

  AST_CLKOUT_ROUTE: assert property (@(posedge clock) disable iff (!rstn)
    co_sel |=> clock_out0_alt_pin_oe && !clock_out0_pin_oe)
    else $error("Clock output on wrong pad");

  AST_APB_READY: assert property (@(posedge clock) disable iff (!rstn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("Ready not one cycle after setup");

endmodule : peripheral_pin_relocation

`default_nettype wire

// ==== pad_model.sv ====
// Pad model for the pin relocation block: the far devices on every input pin and serial clock pin.
// Assumes the bench sets one level for all primary pads and one for all alternates.
`timescale 1ns/1ns
`default_nettype none

module pad_model
  import pin_relocation_pkg::*;
(
  // Levels the far devices put on the pads
  input wire logic [1:0] pattern,
  // Serial clock pad drive from the block
  input wire logic [NUM_SERIAL-1:0] ck_po,
  input wire logic [NUM_SERIAL-1:0] ck_poe,
  input wire logic [NUM_SERIAL-1:0] ck_ao,
  input wire logic [NUM_SERIAL-1:0] ck_aoe,
  // Pad levels into the block
  output logic irq3_p,
  output logic irq3_a1,
  output logic irq3_a2,
  output logic nmi_p,
  output logic nmi_a,
  output logic trg_p,
  output logic trg_a,
  output logic s2_p,
  output logic s2_a,
  output logic [NUM_SERIAL-1:0] rx_p,
  output logic [NUM_SERIAL-1:0] rx_a,
  output logic [NUM_SERIAL-1:0] ck_p_in,
  output logic [NUM_SERIAL-1:0] ck_a_in
);
  ////////////////////////////////////////
  // Primaries carry bit 0, alternates bit 1; first irq3 alternate is inverted
  // so that all three irq3 sources can be told apart
  assign irq3_p = pattern[0];
  assign irq3_a1 = ~pattern[1];
  assign irq3_a2 = pattern[1];
  assign nmi_p = pattern[0];
  assign nmi_a = pattern[1];
  assign trg_p = pattern[0];
  assign trg_a = pattern[1];
  assign s2_p = pattern[0];
  assign s2_a = pattern[1];
  assign rx_p = {NUM_SERIAL{pattern[0]}};
  assign rx_a = {NUM_SERIAL{pattern[1]}};
  ////////////////////////////////////////
  // A pad the block drives shows that drive, else the far device's level
  assign ck_p_in = (ck_poe & ck_po) | (~ck_poe & {NUM_SERIAL{pattern[0]}});
  assign ck_a_in = (ck_aoe & ck_ao) | (~ck_aoe & {NUM_SERIAL{pattern[1]}});
endmodule : pad_model

`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the pin relocation block.
// Assumes the pad model on the far side and an APB master in this module.
`timescale 1ns/1ns
`default_nettype none

module testbench
  import pin_relocation_pkg::*;
;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, fa, ck0_src;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] pattern;
  logic irq3_p, irq3_a1, irq3_a2, nmi_p, nmi_a, trg_p, trg_a, s2_p, s2_a;
  logic [NUM_SERIAL-1:0] rx_p, rx_a, ck_p_in, ck_a_in, tx_po, tx_poe, tx_ao, tx_aoe;
  logic [NUM_SERIAL-1:0] ck_po, ck_poe, ck_ao, ck_aoe, tx_d, tx_en, ck_d, ck_en, rx_q, ck_q;
  logic ck0_p, ck0_poe, ck0_a, ck0_aoe, s2_q, irq3_q, nmi_q, trg_q;
  int n_mismatch, cmp_count;
  logic [11:0] addrs [4] = '{IRQ_NMI_TRIGGER_PIN_SELECT_ADDR, SERIAL_7_8_PIN_SELECT_ADDR,
    CLOCK_OUT0_PIN_SELECT_ADDR, SERIAL2_PIN_SELECT_ADDR};
  logic [7:0] masks [4] = '{IRQ_NMI_TRIGGER_MASK, SERIAL_7_8_MASK, CLOCK_OUT0_MASK, SERIAL2_MASK};
  // Select sets, one byte per register in address order
  logic [7:0] sets [4][4] = '{'{8'h00, 8'h00, 8'h00, 8'h00}, '{8'h0b, 8'h3f, 8'h20, 8'h08},
    '{8'h0a, 8'h15, 8'h00, 8'h08}, '{8'h01, 8'h2a, 8'h20, 8'h00}};

  peripheral_pin_relocation dut_u (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq3_first_alt_select(fa), .ext_irq3_primary_pin(irq3_p),
    .ext_irq3_first_alt_pin(irq3_a1), .ext_irq3_second_alt_pin(irq3_a2),
    .nmi_primary_pin(nmi_p), .nmi_alt_pin(nmi_a), .converter_trigger_pin(trg_p),
    .converter_trigger_alt_pin(trg_a), .serial2_rx_primary_pin(s2_p),
    .serial2_rx_alt_pin(s2_a), .serial_rx_primary_pin(rx_p), .serial_rx_alt_pin(rx_a),
    .serial_tx_primary_out(tx_po), .serial_tx_primary_oe(tx_poe),
    .serial_tx_alt_out(tx_ao), .serial_tx_alt_oe(tx_aoe),
    .serial_clock_primary_in(ck_p_in), .serial_clock_alt_in(ck_a_in),
    .serial_clock_primary_out(ck_po), .serial_clock_primary_oe(ck_poe),
    .serial_clock_alt_out(ck_ao), .serial_clock_alt_oe(ck_aoe),
    .clock_out0_pin(ck0_p), .clock_out0_pin_oe(ck0_poe), .clock_out0_alt_pin(ck0_a),
    .clock_out0_alt_pin_oe(ck0_aoe), .serial_tx_data(tx_d), .serial_tx_enable(tx_en),
    .serial_clock_data(ck_d), .serial_clock_enable(ck_en), .serial_rx_data(rx_q),
    .serial_clock_in(ck_q), .serial2_rx_data(s2_q), .ext_irq3_in(irq3_q), .nmi_in(nmi_q),
    .converter_trigger_in(trg_q), .clock_out0_source(ck0_src));

  pad_model board_u (
    .pattern(pattern), .ck_po(ck_po), .ck_poe(ck_poe), .ck_ao(ck_ao), .ck_aoe(ck_aoe),
    .irq3_p(irq3_p), .irq3_a1(irq3_a1), .irq3_a2(irq3_a2), .nmi_p(nmi_p), .nmi_a(nmi_a),
    .trg_p(trg_p), .trg_a(trg_a), .s2_p(s2_p), .s2_a(s2_a), .rx_p(rx_p), .rx_a(rx_a),
    .ck_p_in(ck_p_in), .ck_a_in(ck_a_in));

  ////////////////////////////////////////
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic chk1(input string nm, input logic seen, input logic exp);
    check(nm, {31'h0, seen}, {31'h0, exp});
  endtask : chk1

  function automatic logic pick(input logic sel, input logic [1:0] pv);
    return sel ? pv[1] : pv[0];
  endfunction : pick

  ////////////////////////////////////////
  // Entered just after an edge; leaves one idle cycle so strobes never toggle twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(nm, r, exp);
    chk1({nm, " error"}, e, exp_err);
  endtask : rd_chk

  task automatic load_set(input int k);
    for (int i = 0; i < 4; i++) begin
      wr(addrs[i], {24'h0, sets[k][i]});
    end
  endtask : load_set

  ////////////////////////////////////////
  task automatic scn_reset_values();
    for (int i = 0; i < 4; i++) begin
      rd_chk("reset value", addrs[i], {24'h0, SELECT_RESET}, 1'b0);
    end
  endtask : scn_reset_values

  task automatic scn_unmapped();
    wr(12'h010, 32'hffffffff);
    rd_chk("unmapped read", 12'h010, 32'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd_chk("after unmapped write", addrs[i], 32'h0, 1'b0);
    end
  endtask : scn_unmapped

  task automatic scn_reserved_bits();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 4; i++) begin
      wr(addrs[i], 32'hffffffff);
      rd_chk("reserved masked", addrs[i], {24'h0, masks[i]}, 1'b0);
      wr(addrs[i], 32'h0);
    end
    // Read-modify-write keeps reserved positions at zero
    apb(1'b0, SERIAL_7_8_PIN_SELECT_ADDR, 32'h0, r, e);
    wr(SERIAL_7_8_PIN_SELECT_ADDR, (r & 32'h3f) | 32'h10);
    rd_chk("read-modify-write", SERIAL_7_8_PIN_SELECT_ADDR, 32'h10, 1'b0);
    wr(SERIAL_7_8_PIN_SELECT_ADDR, 32'h0);
  endtask : scn_reserved_bits

  task automatic scn_input_routes();
    logic [7:0] s0, s1, s3;
    logic i3;
    for (int k = 0; k < 4; k++) begin
      load_set(k);
      s0 = sets[k][0];
      i3 = s0[EXT_IRQ3_SECOND_ALT_BIT];
      s1 = sets[k][1];
      s3 = sets[k][3];
      for (int f = 0; f < 2; f++) begin
        for (int p = 0; p < 4; p++) begin
          fa <= f[0];
          pattern <= p[1:0];
          // Three edges through the synchroniser and output flop, with margin
          repeat (5) @(posedge clock);
          chk1("irq3", irq3_q, f[0] ? ~p[1] : pick(i3, p[1:0]));
          chk1("nmi", nmi_q, pick(s0[NMI_ALT_BIT], p[1:0]));
          chk1("trigger", trg_q, pick(s0[CONVERTER_TRIGGER_ALT_BIT], p[1:0]));
          chk1("serial2 rx", s2_q, pick(s3[SERIAL2_RX_ALT_BIT], p[1:0]));
          chk1("serial7 rx", rx_q[0], pick(s1[SERIAL7_RX_ALT_BIT], p[1:0]));
          chk1("serial8 rx", rx_q[1], pick(s1[SERIAL8_RX_ALT_BIT], p[1:0]));
          chk1("serial7 clock in", ck_q[0], pick(s1[SERIAL7_CLOCK_ALT_BIT], p[1:0]));
          chk1("serial8 clock in", ck_q[1], pick(s1[SERIAL8_CLOCK_ALT_BIT], p[1:0]));
        end
      end
    end
  endtask : scn_input_routes

  task automatic scn_output_routes();
    logic st, sc, so;
    for (int k = 0; k < 4; k++) begin
      load_set(k);
      so = sets[k][2][CLOCK_OUT0_ALT_BIT];
      for (int e = 0; e < 4; e++) begin
        for (int d = 0; d < 4; d++) begin
          tx_d <= d[1:0];
          ck_d <= ~d[1:0];
          tx_en <= e[1:0];
          ck_en <= e[1:0];
          ck0_src <= d[0];
          repeat (2) @(posedge clock);
          for (int i = 0; i < NUM_SERIAL; i++) begin
            st = sets[k][1][i ? SERIAL8_TX_ALT_BIT : SERIAL7_TX_ALT_BIT];
            sc = sets[k][1][i ? SERIAL8_CLOCK_ALT_BIT : SERIAL7_CLOCK_ALT_BIT];
            chk1("tx primary oe", tx_poe[i], e[i] & ~st);
            chk1("tx alt oe", tx_aoe[i], e[i] & st);
            chk1("clock primary oe", ck_poe[i], e[i] & ~sc);
            chk1("clock alt oe", ck_aoe[i], e[i] & sc);
            if (e[i]) begin
              chk1("tx out", st ? tx_ao[i] : tx_po[i], d[i]);
              chk1("clock out", sc ? ck_ao[i] : ck_po[i], ~d[i]);
            end
          end
          chk1("clock0 primary oe", ck0_poe, ~so);
          chk1("clock0 alt oe", ck0_aoe, so);
          chk1("clock0 out", so ? ck0_a : ck0_p, d[0]);
        end
      end
    end
  endtask : scn_output_routes

  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fa = 1'b0;
    ck0_src = 1'b0;
    pattern = 2'h0;
    tx_d = 2'h0;
    tx_en = 2'h0;
    ck_d = 2'h0;
    ck_en = 2'h0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    // Flush the pad synchronisers before the first check
    repeat (3) @(posedge clock);
    scn_reset_values();
    scn_unmapped();
    scn_reserved_bits();
    scn_input_routes();
    scn_output_routes();
    stop_test();
  end
endmodule : testbench

`default_nettype wire
